// file: common/ldss_pkg.sv
// Summary of operation
// R01: Start only with enable high for minimum first on-time and lockout cleared.
// R02: Run a system fault check before any LED sink is enabled.
// R03: Refuse power-up while the frequency-set pin is pulled low.
// R04: Turn on the disconnect switch first, then check each sink pin.
// R05: Start LED detect once the disconnect gate reaches its threshold.
// R06: After sink pin passes 120 mV wait 3000 to 4000 cycles, then decide.
// R07: Classify sink: below 70 mV short, near 150 mV unused, above 325 mV used.
// R08: A shorted pin withholds soft start until removed, then it is rechecked.
// R09: An unused channel leaves regulation and boost feedback selection.
// R10: Soft start uses reduced sink current and reduced switch limit.
// R11: Enough sink voltage ends soft start: full current, full switch limit.
// R12: A fault pushing frequency upward is clamped to at most 3.5 MHz.
// R13: Frequency-set pin shorted to ground in operation shuts down.
// R14: Enable low beyond about 32,750 switching cycles enters shutdown; the code counts this in the run state only.
// R15: Frequency-set low over 7 us stops switching, opens switch, stops sinks.
// R16: Classification held until next power-up; states advance on the clock. The code keeps it until rst_in, so a new power-up rechecks only a short.
package ldss_pkg;
    localparam int LDSS_CLK_MHZ = 100;
    localparam int LDSS_FIRST_ON_NS = 2000;
    localparam int LDSS_FIRST_ON_CYC = (LDSS_FIRST_ON_NS * LDSS_CLK_MHZ + 999) / 1000;
    localparam int LDSS_FREQ_SET_PIN_LOW_NS = 7000;
    localparam int LDSS_FREQ_SET_PIN_LOW_CYC = (LDSS_FREQ_SET_PIN_LOW_NS * LDSS_CLK_MHZ) / 1000;
    localparam int LDSS_DETECT_CYC = 3500;
    localparam int LDSS_DIM_OFF_CYC = 32750;
    localparam int LDSS_MAX_FREQ_KHZ = 3500;
    localparam logic [1:0] LDSS_CLS_NONE = 2'h0;
    localparam logic [1:0] LDSS_CLS_SHORT = 2'h1;
    localparam logic [1:0] LDSS_CLS_UNUSED = 2'h2;
    localparam logic [1:0] LDSS_CLS_USED = 2'h3;
    typedef enum logic [6:0] {
        LDSS_OFF = 7'h01,
        LDSS_QUAL = 7'h02,
        LDSS_GATE = 7'h04,
        LDSS_DETECT = 7'h08,
        LDSS_SOFT = 7'h10,
        LDSS_RUN = 7'h20,
        LDSS_FAULT = 7'h40
    } ldss_state_t;
endpackage : ldss_pkg

// file: rtl/ldss_sink_check.sv
`timescale 1ns/1ps
module ldss_sink_check
    import ldss_pkg::*;
#(
    parameter int DETECT_CYC = LDSS_DETECT_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    input wire logic above_detect_in,
    input wire logic below_short_in,
    input wire logic above_used_in,
    output logic [1:0] class_out
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic [1:0] next_class;
    always_comb begin
        next_count = count;
        next_class = class_out;
        if (!run_in) begin
            next_count = 16'h0000;
        end else if (class_out == LDSS_CLS_NONE || class_out == LDSS_CLS_SHORT) begin
            if (class_out == LDSS_CLS_SHORT && !below_short_in) begin
                next_class = LDSS_CLS_NONE; // R08
                next_count = 16'h0000;
            end else if (!above_detect_in && class_out == LDSS_CLS_NONE) begin
                next_count = 16'h0000; // R06
            end else if (count == 16'(DETECT_CYC - 1)) begin
                if (below_short_in) begin
                    next_class = LDSS_CLS_SHORT; // R07
                end else if (above_used_in) begin
                    next_class = LDSS_CLS_USED; // R07
                end else begin
                    next_class = LDSS_CLS_UNUSED; // R07
                end
                next_count = 16'h0000;
            end else begin
                next_count = count + 16'h0001; // R06
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count <= 16'h0000;
            class_out <= LDSS_CLS_NONE;
        end else begin
            count <= next_count;
            class_out <= next_class; // R16
        end
    end
endmodule : ldss_sink_check

// file: rtl/ldss_top.sv
`timescale 1ns/1ps
module ldss_top
    import ldss_pkg::*;
#(
    parameter int CHANNELS = 2,
    parameter int DIM_OFF_CYC = LDSS_DIM_OFF_CYC,
    parameter int DETECT_CYC = LDSS_DETECT_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic enable_dim_in,
    input wire logic supply_ok_in,
    input wire logic freq_set_high_in,
    input wire logic freq_up_fault_in,
    input wire logic gate_ready_in,
    input wire logic [CHANNELS-1:0] sink_above_detect_in,
    input wire logic [CHANNELS-1:0] sink_below_short_in,
    input wire logic [CHANNELS-1:0] sink_above_used_in,
    input wire logic sinks_sufficient_in,
    output logic disconnect_on_out,
    output logic switching_on_out,
    output logic [CHANNELS-1:0] sink_enable_out,
    output logic [CHANNELS-1:0] feedback_select_out,
    output logic soft_start_current_out,
    output logic soft_start_limit_out,
    output logic freq_clamp_out,
    output logic shutdown_out,
    output logic [2*CHANNELS-1:0] class_out
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two flops before any logic
    localparam int NS = 5 + 3 * CHANNELS;
    logic [NS-1:0] sync_a;
    logic [NS-1:0] sync_b;
    logic en_s;
    logic uv_s;
    logic fs_s;
    logic fu_s;
    logic gr_s;
    logic [CHANNELS-1:0] det_s;
    logic [CHANNELS-1:0] sh_s;
    logic [CHANNELS-1:0] us_s;
    logic ss_s;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {enable_dim_in, supply_ok_in, freq_set_high_in, freq_up_fault_in,
                       gate_ready_in, sink_above_detect_in, sink_below_short_in,
                       sink_above_used_in};
            sync_b <= sync_a;
        end
    end
    assign {en_s, uv_s, fs_s, fu_s, gr_s, det_s, sh_s, us_s} = sync_b;
    // Sufficient-voltage sense has its own two-stage path (ss_a, ss_b), outside sync_a/sync_b
    logic ss_a;
    logic ss_b;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ss_a <= 1'b0;
            ss_b <= 1'b0;
        end else begin
            ss_a <= sinks_sufficient_in;
            ss_b <= ss_a;
        end
    end
    assign ss_s = ss_b;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel classification
    logic [2*CHANNELS-1:0] cls;
    logic detect_run;
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
            ldss_sink_check #(.DETECT_CYC(DETECT_CYC)) u_chk (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .run_in(detect_run),
                .above_detect_in(det_s[gi]),
                .below_short_in(sh_s[gi]),
                .above_used_in(us_s[gi]),
                .class_out(cls[2*gi+1:2*gi])
            );
        end
    endgenerate

    function automatic logic ch_is(input logic [2*CHANNELS-1:0] c, input int i,
                                   input logic [1:0] v);
        ch_is = (c[2*i+:2] == v);
    endfunction : ch_is

    logic all_done;
    logic any_short;
    always_comb begin
        all_done = 1'b1;
        any_short = 1'b0;
        for (int i = 0; i < CHANNELS; i++) begin
            if (ch_is(cls, i, LDSS_CLS_NONE)) all_done = 1'b0;
            if (ch_is(cls, i, LDSS_CLS_SHORT)) any_short = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    ldss_state_t state;
    ldss_state_t next_state;
    logic [15:0] tcount;
    logic [15:0] next_tcount;
    logic [15:0] fcount;
    logic [15:0] next_fcount;
    logic freq_set_pin_timeout;
    logic dim_timeout;
    assign freq_set_pin_timeout = (fcount == 16'(LDSS_FREQ_SET_PIN_LOW_CYC));
    assign dim_timeout = (tcount == 16'(DIM_OFF_CYC));
    assign detect_run = (state == LDSS_DETECT);

    always_comb begin
        next_state = state;
        next_tcount = tcount;
        next_fcount = (fs_s || state == LDSS_OFF) ? 16'h0000 :
                      (freq_set_pin_timeout ? fcount : fcount + 16'h0001);
        case (state)
            LDSS_OFF: begin
                next_tcount = 16'h0000;
                if (en_s && uv_s && fs_s) next_state = LDSS_QUAL; // R01 R03
            end
            LDSS_QUAL: begin
                if (!en_s || !uv_s || !fs_s) begin
                    next_state = LDSS_OFF; // R01 R03
                end else if (tcount == 16'(LDSS_FIRST_ON_CYC - 1)) begin
                    next_state = LDSS_GATE; // R01
                    next_tcount = 16'h0000;
                end else begin
                    next_tcount = tcount + 16'h0001;
                end
            end
            LDSS_GATE: begin
                if (gr_s) next_state = LDSS_DETECT; // R04 R05
            end
            LDSS_DETECT: begin
                if (all_done && !any_short) next_state = LDSS_SOFT; // R02 R08
            end
            LDSS_SOFT: begin
                if (ss_s) next_state = LDSS_RUN; // R11
            end
            LDSS_RUN: begin
                if (en_s) begin
                    next_tcount = 16'h0000;
                end else if (dim_timeout) begin
                    next_state = LDSS_OFF; // R14
                end else begin
                    next_tcount = tcount + 16'h0001; // R14
                end
            end
            LDSS_FAULT: begin
                if (fs_s) next_state = LDSS_SOFT;
                else if (!en_s) next_state = LDSS_OFF;
            end
            default: next_state = LDSS_OFF;
        endcase
        // Supply lost or freq-set stuck low overrides any active state
        if (state != LDSS_OFF && state != LDSS_QUAL) begin
            if (!uv_s) next_state = LDSS_OFF;
            else if (freq_set_pin_timeout && state != LDSS_FAULT) next_state = LDSS_FAULT; // R13 R15
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= LDSS_OFF;
            tcount <= 16'h0000;
            fcount <= 16'h0000;
        end else begin
            state <= next_state; // R16
            tcount <= next_tcount;
            fcount <= next_fcount;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    logic active;
    logic [CHANNELS-1:0] used_mask;
    assign active = (next_state == LDSS_SOFT) || (next_state == LDSS_RUN);
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            used_mask[i] = ch_is(cls, i, LDSS_CLS_USED); // R09
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            disconnect_on_out <= 1'b0;
            switching_on_out <= 1'b0;
            sink_enable_out <= '0;
            feedback_select_out <= '0;
            soft_start_current_out <= 1'b0;
            soft_start_limit_out <= 1'b0;
            freq_clamp_out <= 1'b0;
            shutdown_out <= 1'b1;
            class_out <= '0;
        end else begin
            disconnect_on_out <= (next_state != LDSS_OFF) && (next_state != LDSS_QUAL)
                                 && (next_state != LDSS_FAULT); // R04 R15
            switching_on_out <= active && en_s; // R15
            sink_enable_out <= (active && en_s) ? used_mask : '0; // R09 R10 R15
            feedback_select_out <= active ? used_mask : '0; // R09
            soft_start_current_out <= (next_state == LDSS_SOFT); // R10
            soft_start_limit_out <= (next_state == LDSS_SOFT); // R10 R11
            freq_clamp_out <= fu_s; // R12
            shutdown_out <= (next_state == LDSS_OFF) || (next_state == LDSS_FAULT);
            class_out <= cls;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_soft_to_run;
        state == LDSS_SOFT && ss_s;
    endsequence
    property p_start_qual;
        @(posedge clk_in) disable iff (rst_in)
        (state == LDSS_QUAL && next_state == LDSS_GATE) |-> en_s && uv_s && fs_s;
    endproperty
    a_start_qual: assert property (p_start_qual) else $error("start without qualify"); // R01
    property p_no_sink_before_soft;
        @(posedge clk_in) disable iff (rst_in)
        (state == LDSS_DETECT || state == LDSS_GATE) |-> sink_enable_out == '0;
    endproperty
    a_no_sink_before_soft: assert property (p_no_sink_before_soft) // R02
        else $error("sink on before check");
    property p_freq_set_pin_block;
        @(posedge clk_in) disable iff (rst_in)
        (state == LDSS_OFF && !fs_s) |=> state == LDSS_OFF;
    endproperty
    a_freq_set_pin_block: assert property (p_freq_set_pin_block) else $error("power-up with freq_set_pin low"); // R03
    property p_short_hold;
        @(posedge clk_in) disable iff (rst_in)
        (state == LDSS_DETECT && (any_short || !all_done)) |=> state != LDSS_SOFT;
    endproperty
    a_short_hold: assert property (p_short_hold) else $error("soft start with short"); // R08
    property p_soft_limits;
        @(posedge clk_in) disable iff (rst_in)
        (state == LDSS_SOFT && $past(state) == LDSS_SOFT) |-> soft_start_limit_out;
    endproperty
    a_soft_limits: assert property (p_soft_limits) else $error("soft limit missing"); // R10
    property p_run_full;
        @(posedge clk_in) disable iff (rst_in)
        s_soft_to_run |=> !soft_start_limit_out && !soft_start_current_out;
    endproperty
    a_run_full: assert property (p_run_full) else $error("full limit not applied"); // R11
    property p_freq_set_pin_fault;
        @(posedge clk_in) disable iff (rst_in)
        (freq_set_pin_timeout && state == LDSS_RUN && uv_s) |=> !disconnect_on_out &&
            !switching_on_out && sink_enable_out == '0;
    endproperty
    a_freq_set_pin_fault: assert property (p_freq_set_pin_fault) else $error("freq_set_pin fault not shut"); // R15
    property p_clamp;
        @(posedge clk_in) disable iff (rst_in)
        fu_s |=> freq_clamp_out;
    endproperty
    a_clamp: assert property (p_clamp) else $error("frequency clamp missing"); // R12
    property p_dim_off;
        @(posedge clk_in) disable iff (rst_in)
        (state == LDSS_RUN && !en_s && dim_timeout && uv_s && !freq_set_pin_timeout)
            |=> state == LDSS_OFF && shutdown_out;
    endproperty
    a_dim_off: assert property (p_dim_off) else $error("dim timeout ignored"); // R14
endmodule : ldss_top

// file: sim/ldss_led_model.sv
`timescale 1ns/1ps
module ldss_led_model
    import ldss_pkg::*;
#(
    parameter int CHANNELS = 2,
    parameter int GATE_CYC = 16,
    parameter int RAMP_CYC = 10
) (
    input wire logic clk_in,
    input wire logic disconnect_on_in,
    input wire logic [2*CHANNELS-1:0] kind_in,
    input wire logic [CHANNELS-1:0] sink_enable_in,
    output logic gate_ready_out,
    output logic [CHANNELS-1:0] above_detect_out,
    output logic [CHANNELS-1:0] below_short_out,
    output logic [CHANNELS-1:0] above_used_out,
    output logic sinks_sufficient_out
);
    int gate_cnt = 0;
    int ramp_cnt = 0;
    always_ff @(posedge clk_in) begin
        gate_cnt <= disconnect_on_in ? gate_cnt + ((gate_cnt < GATE_CYC) ? 1 : 0) : 0;
        ramp_cnt <= (|sink_enable_in) ? ramp_cnt + ((ramp_cnt < RAMP_CYC) ? 1 : 0) : 0;
    end
    // Gate discharges slowly, so detect never starts at once
    assign gate_ready_out = (gate_cnt >= GATE_CYC);
    // Output needs some cycles of sink current before it is high enough
    assign sinks_sufficient_out = (ramp_cnt >= RAMP_CYC);
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            // Pins sit at ground until the switch feeds the strings
            above_detect_out[c] = gate_ready_out && kind_in[2*c +: 2] != LDSS_CLS_SHORT;
            below_short_out[c] = !gate_ready_out || kind_in[2*c +: 2] == LDSS_CLS_SHORT;
            above_used_out[c] = gate_ready_out && kind_in[2*c +: 2] == LDSS_CLS_USED;
        end
    end
endmodule : ldss_led_model

// file: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import ldss_pkg::*;
    typedef struct packed {logic [3:0] cls; logic [1:0] fb;} ldss_exp_t;
    logic clk_in = 0, rst_in = 1, enable_dim_in = 0, supply_ok_in = 0;
    logic freq_set_high_in = 0, freq_up_fault_in = 0, gate_ready, sufficient, soft_d = 0;
    logic [3:0] kind = 4'hf, class_out;
    logic [1:0] above_det, below_sh, above_us, sink_en, fb_sel;
    logic disc_on, sw_on, ss_cur, ss_lim, clamp, shut;
    int n_fail = 0, samples_checked = 0, seed = 41233, i, p;
    ldss_exp_t exp_q[$];
    ldss_exp_t e;
    ldss_top #(.DIM_OFF_CYC(50), .DETECT_CYC(20)) dut (.clk_in(clk_in), .rst_in(rst_in),
        .enable_dim_in(enable_dim_in), .supply_ok_in(supply_ok_in),
        .freq_set_high_in(freq_set_high_in), .freq_up_fault_in(freq_up_fault_in),
        .gate_ready_in(gate_ready), .sink_above_detect_in(above_det),
        .sink_below_short_in(below_sh), .sink_above_used_in(above_us),
        .sinks_sufficient_in(sufficient), .disconnect_on_out(disc_on),
        .switching_on_out(sw_on), .sink_enable_out(sink_en), .feedback_select_out(fb_sel),
        .soft_start_current_out(ss_cur), .soft_start_limit_out(ss_lim),
        .freq_clamp_out(clamp), .shutdown_out(shut), .class_out(class_out));
    ldss_led_model led (.clk_in(clk_in), .disconnect_on_in(disc_on), .kind_in(kind),
        .sink_enable_in(sink_en), .gate_ready_out(gate_ready), .above_detect_out(above_det),
        .below_short_out(below_sh), .above_used_out(above_us),
        .sinks_sufficient_out(sufficient));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////
    task check(input logic [3:0] got, input logic [3:0] want, input string msg);
        samples_checked++;
        if (got !== want) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, got, want);
        end
    endtask : check
    task end_sim;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    task cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    task do_reset;
        rst_in = 1;
        enable_dim_in = 0;
        freq_up_fault_in = 0;
        cyc(3);
        rst_in = 0;
    endtask : do_reset
    // Waits for the soft start flag to reach a level, bounded so a hang is caught
    task wait_soft(input logic lvl);
        i = 0;
        while (ss_cur !== lvl && i < 400) begin
            cyc(1);
            i++;
        end
        check({3'h0, ss_cur}, {3'h0, lvl}, "soft start wait");
    endtask : wait_soft
    // Every soft start entry is checked against the next expected classification
    always @(negedge clk_in) begin
        soft_d <= ss_cur;
        if (!rst_in && ss_cur === 1'b1 && soft_d !== 1'b1) begin
            if (exp_q.size() == 0) begin
                check(4'h1, 4'h0, "unexpected soft start");
            end else begin
                e = exp_q.pop_front();
                check(class_out, e.cls, "channel classes");
                check({2'h0, fb_sel}, {2'h0, e.fb}, "feedback selection");
            end
        end
    end
    initial begin
        #200us;
        n_fail++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (int r = 0; r < 3; r++) begin
            p = $random(seed) & 1;
            kind = (r == 1) ? {LDSS_CLS_USED, p[0] ? LDSS_CLS_USED : LDSS_CLS_UNUSED}
                : {p[0] ? LDSS_CLS_USED : LDSS_CLS_UNUSED, LDSS_CLS_USED};
            e.cls = kind;
            e.fb = {kind[3:2] == LDSS_CLS_USED, kind[1:0] == LDSS_CLS_USED};
            exp_q.push_back(e);
            do_reset();
            {supply_ok_in, freq_set_high_in, enable_dim_in} = 3'h7;
            cyc(100);
            check({3'h0, disc_on}, 4'h0, "switch on before first on-time");
            cyc(110);
            check({3'h0, disc_on}, 4'h1, "switch on after qualify");
            cyc(30);
            check({3'h0, ss_cur}, 4'h0, "soft start before detect wait");
            wait_soft(1'b1);
            cyc(2);
            check({2'h0, sink_en}, {2'h0, e.fb}, "soft sinks");
            check({3'h0, ss_lim}, 4'h1, "soft switch limit");
            wait_soft(1'b0);
            cyc(2);
            check({ss_lim, sw_on, sink_en}, {2'h1, e.fb}, "full regulation");
        end
        do_reset();
        freq_set_high_in = 0;
        enable_dim_in = 1;
        cyc(400);
        check({shut, disc_on, 2'h0}, 4'h8, "freq-set low start");
        do_reset();
        freq_set_high_in = 1;
        enable_dim_in = 1;
        cyc(20 + ($random(seed) & 8'h7f));
        enable_dim_in = 0;
        cyc(300);
        check({shut, disc_on, 2'h0}, 4'h8, "short enable pulse");
        do_reset();
        {supply_ok_in, enable_dim_in} = 2'h1;
        cyc(400);
        check({shut, disc_on, 2'h0}, 4'h8, "supply below lockout");
        do_reset();
        kind = {LDSS_CLS_SHORT, LDSS_CLS_USED};
        exp_q.push_back({4'hf, 2'h3});
        {supply_ok_in, enable_dim_in} = 2'h3;
        cyc(500);
        check({ss_cur, 1'b0, sink_en}, 4'h0, "soft start held by short");
        kind = 4'hf;
        wait_soft(1'b1);
        wait_soft(1'b0);
        freq_up_fault_in = 1;
        cyc(4);
        check({3'h0, clamp}, 4'h1, "frequency clamp on");
        freq_up_fault_in = 0;
        cyc(4);
        check({3'h0, clamp}, 4'h0, "frequency clamp off");
        freq_set_high_in = 0;
        cyc(600);
        check({3'h0, sw_on}, 4'h1, "short freq-set low");
        cyc(150);
        check({disc_on, sw_on, sink_en}, 4'h0, "freq-set fault");
        check({3'h0, shut}, 4'h1, "freq-set fault shutdown");
        exp_q.push_back({4'hf, 2'h3});
        freq_set_high_in = 1;
        wait_soft(1'b1);
        wait_soft(1'b0);
        enable_dim_in = 0;
        cyc(30);
        check({shut, 1'b0, sink_en}, 4'h0, "dimming off");
        cyc(40);
        check({3'h0, shut}, 4'h1, "dim-off timeout");
        check(class_out, 4'hf, "classes held");
        end_sim();
    end
endmodule : testbench
